/* File: verilog/nvtc_defines.svh */
`ifndef NVTC_DEFINES_SVH
`define NVTC_DEFINES_SVH

// Field positions inside the hypervisor configuration word
`define NVTC_POS_REDIR 45
`define NVTC_POS_NEST_DESC 43
`define NVTC_POS_NEST 42
`define NVTC_POS_PAUTH 41
`define NVTC_POS_KEY 40
`define NVTC_POS_TXN 39

// Value every control field takes on reset
`define NVTC_FIELD_RESET 1'h0

// Syndrome class codes
`define NVTC_CLASS_NONE 6'h00
`define NVTC_CLASS_PAUTH 6'h09
`define NVTC_CLASS_SECURE_CALL 6'h17
`define NVTC_CLASS_SYSREG 6'h18
`define NVTC_CLASS_EXC_RETURN 6'h1A

// Privilege level codes
`define NVTC_LVL_USER 2'h0
`define NVTC_LVL_KERNEL 2'h1
`define NVTC_LVL_HYP 2'h2

// Level shown to a nested guest reading the current-level register
`define NVTC_GUEST_LEVEL 2'h2

`endif

/* File: verilog/nvtc_pkg.sv */
package nvtc_pkg;

  // Kind of operation presented by the pipeline
  typedef enum logic [3:0] {
    NVTC_OP_NONE,
    NVTC_OP_SYSREG_HYP,
    NVTC_OP_SYSREG_HYP_REDIR,
    NVTC_OP_SYSREG_HYP_SP,
    NVTC_OP_SYSREG_ALIAS,
    NVTC_OP_SPSR_BANKED,
    NVTC_OP_KERNEL_SP,
    NVTC_OP_READ_LEVEL,
    NVTC_OP_HYP_TRANSLATE,
    NVTC_OP_EXC_RETURN,
    NVTC_OP_EXC_RETURN_AUTH,
    NVTC_OP_SECURE_CALL,
    NVTC_OP_PAUTH,
    NVTC_OP_KEY_REG,
    NVTC_OP_TRANSACTION,
    NVTC_OP_OTHER
  } nvtc_op_t;

  // Choice taken when the nested-trap field is 0 and the descriptor field is 1
  typedef enum logic [1:0] {
    NVTC_MIX_AS_BOTH_SET,
    NVTC_MIX_AS_BOTH_CLEAR,
    NVTC_MIX_AS_WRITTEN
  } nvtc_mix_t;

endpackage

/* File: verilog/nvtc_ctrl_bit.sv */
`timescale 1ns/1ns
`default_nettype none
`include "nvtc_defines.svh"

module nvtc_ctrl_bit #(
  parameter logic RESET_VAL = `NVTC_FIELD_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Write side
  input wire logic wrEn,
  input wire logic wrData,
  // Stored value
  output logic fieldQ
);

  // One writable control bit; reset gives a fixed value software must overwrite
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fieldQ <= RESET_VAL;
    end else if (wrEn) begin
      fieldQ <= wrData;
    end
  end

endmodule
`default_nettype wire

/* File: verilog/nvtc_trap_control.sv */
`timescale 1ns/1ns
`default_nettype none
`include "nvtc_defines.svh"

// Notes on behaviour
// - Mixed nested fields follow a fixed chosen policy
// - Control fields need software write after reset
// - Translation view updates only on invalidate
// - Redirection swaps four hypervisor registers to kernel
// - Nested trap clear disables redirection and nested traps
// - Nested trap catches listed operations when enabled
// - Guest reading current level sees value two
// - Hypervisor register moves trap with class 0x18
// - Hypervisor translation maintenance traps with 0x18
// - Exception returns trap with class 0x1A
// - Nested trap outranks pointer-auth trap
// - Secure call traps 0x17 without monitor
// - Pointer-auth instructions trap with 0x09
// - Fine-grained return trap outranks pointer-auth
// - Hypervisor off makes auth fields read one
// - Key register accesses trap with 0x18
// - Transaction clear makes transaction ops undefined
// - Hypervisor off forces transaction field one
module nvtc_trap_control import nvtc_pkg::*; #(
  parameter nvtc_mix_t MIX_POLICY = NVTC_MIX_AS_WRITTEN,
  parameter int CFG_WIDTH = 64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration register access
  input wire logic cfgWrite,
  input wire logic [CFG_WIDTH-1:0] cfgWriteData,
  input wire logic cfgRead,
  output logic cfgReadValid,
  output logic [CFG_WIDTH-1:0] cfgReadData,
  // Translation cache maintenance
  input wire logic tlbInvalidate,
  output logic descFormatAlt,
  // System context
  input wire logic hypEnabled,
  input wire logic monitorPresent,
  input wire logic trapGeneral,
  input wire logic hostAtHyp,
  input wire logic secureCallTrap,
  input wire logic fineExcReturnTrap,
  input wire logic pauthEnabledLower,
  // Operation issue
  input wire logic opValid,
  input wire nvtc_op_t opKind,
  input wire logic [1:0] opLevel,
  input wire logic [1:0] opRedirIdx,
  // Decision
  output logic resValid,
  output logic resTrap,
  output logic [5:0] resClass,
  output logic resUndefined,
  output logic resCommit,
  output logic resRedirect,
  output logic [1:0] resRedirIdx,
  output logic [1:0] resLevelValue
);

  ////////////////////////////////////////////////////////////////////////////
  // Control field storage

  localparam int NUM_FIELDS = 6;
  localparam int FIELD_POS [NUM_FIELDS] = '{`NVTC_POS_TXN, `NVTC_POS_KEY, `NVTC_POS_PAUTH,
                                            `NVTC_POS_NEST, `NVTC_POS_NEST_DESC, `NVTC_POS_REDIR};

  logic [NUM_FIELDS-1:0] fieldQ;
  logic txnQ, keyQ, pauthQ, nestQ, nestDescQ, redirQ;

  // One storage bit per field; reset value is arbitrary from software's view
  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g = g + 1) begin : gField
      nvtc_ctrl_bit #(.RESET_VAL(`NVTC_FIELD_RESET)) uBit (
        .clk(clk),
        .rst(rst),
        .wrEn(cfgWrite),
        .wrData(cfgWriteData[FIELD_POS[g]]),
        .fieldQ(fieldQ[g])
      );
    end
  endgenerate

  assign txnQ = fieldQ[0];
  assign keyQ = fieldQ[1];
  assign pauthQ = fieldQ[2];
  assign nestQ = fieldQ[3];
  assign nestDescQ = fieldQ[4];
  assign redirQ = fieldQ[5];

  ////////////////////////////////////////////////////////////////////////////
  // Read-back: raw stored bits only, never the effective values

  logic [CFG_WIDTH-1:0] readWord;

  // Assemble the word; fields outside this block read as zero
  always_comb begin
    readWord = '0;
    for (int i = 0; i < NUM_FIELDS; i++) begin
      readWord[FIELD_POS[i]] = fieldQ[i];
    end
  end

  // Answer one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgReadValid <= 1'b0;
      cfgReadData <= '0;
    end else begin
      cfgReadValid <= cfgRead;
      if (cfgRead) begin
        cfgReadData <= readWord;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective field values

  logic nestEff, nestDescEff, redirEff, pauthEff, keyEff, txnEff;

  // Mixed nested setting resolved by a fixed policy
  always_comb begin
    nestEff = nestQ;
    nestDescEff = nestDescQ;
    if (!nestQ && nestDescQ) begin
      case (MIX_POLICY)
        NVTC_MIX_AS_BOTH_SET: begin
          nestEff = 1'b1;
          nestDescEff = 1'b1;
        end
        NVTC_MIX_AS_BOTH_CLEAR: begin
          nestEff = 1'b0;
          nestDescEff = 1'b0;
        end
        default: begin
          nestEff = nestQ;
          nestDescEff = nestDescQ;
        end
      endcase
    end
  end

  // Redirection only counts while the nested trap is set
  assign redirEff = redirQ && nestEff;
  // Hypervisor off reads the auth and transaction fields as one
  assign pauthEff = pauthQ || !hypEnabled;
  assign keyEff = keyQ || !hypEnabled;
  assign txnEff = txnQ || !hypEnabled;

  ////////////////////////////////////////////////////////////////////////////
  // Translation cache view of the nested fields

  logic tlbNestQ, tlbNestDescQ;

  // Entries may hold stale fields; they refresh only on invalidate
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tlbNestQ <= 1'b0;
      tlbNestDescQ <= 1'b0;
    end else if (tlbInvalidate) begin
      tlbNestQ <= nestEff;
      tlbNestDescQ <= nestDescEff;
    end
  end

  assign descFormatAlt = tlbNestQ && tlbNestDescQ;

  ////////////////////////////////////////////////////////////////////////////
  // Trap decision

  logic atKernel, nestTrapOn, pauthTrapOn, trapD, undefD, redirD;
  logic [5:0] classD;
  logic [1:0] levelD;

  assign atKernel = (opLevel == `NVTC_LVL_KERNEL);
  // Nested trap acts only without redirection and with the hypervisor on
  assign nestTrapOn = nestEff && !redirEff && hypEnabled && atKernel;
  // User level escapes when both host-mode controls are set
  assign pauthTrapOn = !pauthEff && pauthEnabledLower &&
                       (atKernel || (opLevel == `NVTC_LVL_USER && !(trapGeneral && hostAtHyp)));

  // Priority: nested, then fine-grained, then pointer-auth
  always_comb begin
    trapD = 1'b0;
    classD = `NVTC_CLASS_NONE;
    undefD = 1'b0;
    redirD = 1'b0;
    levelD = opLevel;
    case (opKind)
      NVTC_OP_SYSREG_HYP, NVTC_OP_SYSREG_ALIAS, NVTC_OP_SPSR_BANKED,
      NVTC_OP_KERNEL_SP: begin
        if (nestTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_SYSREG;
        end
      end
      NVTC_OP_SYSREG_HYP_REDIR: begin
        if (redirEff && hypEnabled && atKernel) begin
          redirD = 1'b1;
        end else if (nestTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_SYSREG;
        end
      end
      NVTC_OP_HYP_TRANSLATE: begin
        if (nestTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_SYSREG;
        end
      end
      NVTC_OP_READ_LEVEL: begin
        if (nestTrapOn) begin
          levelD = `NVTC_GUEST_LEVEL;
        end
      end
      NVTC_OP_EXC_RETURN: begin
        if (nestTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_EXC_RETURN;
        end
      end
      NVTC_OP_EXC_RETURN_AUTH: begin
        if (nestTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_EXC_RETURN;
        end else if (fineExcReturnTrap && hypEnabled && atKernel) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_EXC_RETURN;
        end else if (pauthTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_PAUTH;
        end
      end
      NVTC_OP_SECURE_CALL: begin
        if (nestTrapOn && !monitorPresent && secureCallTrap) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_SECURE_CALL;
        end
      end
      NVTC_OP_PAUTH: begin
        if (pauthTrapOn) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_PAUTH;
        end
      end
      NVTC_OP_KEY_REG: begin
        if (!keyEff && atKernel) begin
          trapD = 1'b1;
          classD = `NVTC_CLASS_SYSREG;
        end
      end
      NVTC_OP_TRANSACTION: begin
        if (!txnEff && (atKernel || opLevel == `NVTC_LVL_USER)) begin
          undefD = 1'b1;
        end
      end
      default: begin
        trapD = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decision register: one cycle after issue

  // Held outputs keep their last decision between operations
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resValid <= 1'b0;
      resTrap <= 1'b0;
      resClass <= `NVTC_CLASS_NONE;
      resUndefined <= 1'b0;
      resRedirect <= 1'b0;
      resRedirIdx <= 2'h0;
      resLevelValue <= `NVTC_LVL_USER;
    end else begin
      resValid <= opValid;
      if (opValid) begin
        resTrap <= trapD;
        resClass <= classD;
        resUndefined <= undefD;
        resRedirect <= redirD;
        resRedirIdx <= opRedirIdx;
        resLevelValue <= levelD;
      end
    end
  end

  // A trapped or undefined operation leaves state untouched
  assign resCommit = resValid && !resTrap && !resUndefined;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_READBACK_RAW: assert property (cfgWrite ##1 cfgRead |=>
    cfgReadValid && cfgReadData[`NVTC_POS_NEST] == $past(cfgWriteData[`NVTC_POS_NEST], 2) &&
    cfgReadData[`NVTC_POS_NEST_DESC] == $past(cfgWriteData[`NVTC_POS_NEST_DESC], 2))
    else $error("read-back differs from written field");

  AST_TLB_HOLD: assert property (!tlbInvalidate |=> $stable(descFormatAlt))
    else $error("translation view moved without invalidate");

  AST_REDIRECT: assert property (opValid && opKind == NVTC_OP_SYSREG_HYP_REDIR && atKernel &&
    hypEnabled && redirEff |=> resValid && resRedirect && !resTrap && resRedirIdx == $past(opRedirIdx))
    else $error("redirection not applied");

  AST_NEST_OFF: assert property (opValid && !nestEff && opKind == NVTC_OP_SYSREG_HYP |=> !resTrap)
    else $error("trap raised with nested trap clear");

  AST_HYP_OFF: assert property (opValid && !hypEnabled && opKind != NVTC_OP_TRANSACTION |=>
    !resTrap) else $error("trap raised with hypervisor off");

  AST_GUEST_LEVEL: assert property (opValid && opKind == NVTC_OP_READ_LEVEL && nestTrapOn |=>
    resLevelValue == `NVTC_GUEST_LEVEL && !resTrap) else $error("guest level not shown as two");

  AST_BANKED_TRAP: assert property (opValid && nestTrapOn && opKind == NVTC_OP_SPSR_BANKED |=>
    resTrap && resClass == `NVTC_CLASS_SYSREG) else $error("banked status not trapped");

  AST_HYP_SP_FREE: assert property (opValid && opKind == NVTC_OP_SYSREG_HYP_SP |=> !resTrap)
    else $error("hypervisor stack pointer trapped");

  AST_TRANSLATE: assert property (opValid && nestTrapOn && opKind == NVTC_OP_HYP_TRANSLATE |=>
    resTrap && resClass == `NVTC_CLASS_SYSREG) else $error("translation op not trapped");

  AST_RETURN_PRIO: assert property (opValid && nestTrapOn && pauthTrapOn &&
    opKind == NVTC_OP_EXC_RETURN_AUTH |=> resClass == `NVTC_CLASS_EXC_RETURN)
    else $error("auth return class wrong");

  AST_SECURE_CALL: assert property (opValid && nestTrapOn && !monitorPresent && secureCallTrap &&
    opKind == NVTC_OP_SECURE_CALL |=> resTrap && resClass == `NVTC_CLASS_SECURE_CALL)
    else $error("secure call not trapped");

  AST_PAUTH: assert property (opValid && !pauthQ && hypEnabled && pauthEnabledLower && atKernel &&
    opKind == NVTC_OP_PAUTH |=> resTrap && resClass == `NVTC_CLASS_PAUTH)
    else $error("pointer-auth op not trapped");

  AST_FINE_RETURN: assert property (opValid && !nestTrapOn && fineExcReturnTrap && hypEnabled &&
    atKernel && opKind == NVTC_OP_EXC_RETURN_AUTH |=> resClass == `NVTC_CLASS_EXC_RETURN)
    else $error("fine-grained return class wrong");

  AST_KEY_REG: assert property (opValid && !keyQ && hypEnabled && atKernel &&
    opKind == NVTC_OP_KEY_REG |=> resTrap && resClass == `NVTC_CLASS_SYSREG)
    else $error("key register access not trapped");

  AST_TXN: assert property (opValid && opKind == NVTC_OP_TRANSACTION && atKernel |=>
    resUndefined == $past(!txnQ && hypEnabled)) else $error("transaction undefined mismatch");

  AST_NO_COMMIT: assert property (resValid && resTrap |-> !resCommit &&
    resClass != `NVTC_CLASS_NONE) else $error("trap without class or with commit");

  COV_REDIRECT: cover property (opValid && opKind == NVTC_OP_SYSREG_HYP_REDIR ##1 resRedirect);
  COV_AUTH_RETURN: cover property (opValid && opKind == NVTC_OP_EXC_RETURN_AUTH ##1 resTrap);
  COV_PAUTH: cover property (resValid && resClass == `NVTC_CLASS_PAUTH);
  COV_TXN_UNDEF: cover property (resValid && resUndefined);

endmodule
`default_nettype wire

/* File: testbench/nvtc_pipe_model.sv */
`timescale 1ns/1ns
`default_nettype none

module nvtc_pipe_model import nvtc_pkg::*; (
  // Clock
  input wire logic clk,
  // Issue side
  output logic opValid,
  output nvtc_op_t opKind,
  output logic [1:0] opLevel,
  output logic [1:0] opRedirIdx
);
  logic [3:0] junk;

  //////////////////////////////////////////////////////////////////////////////
  // Issue slot, called just after each rising edge of clk
  // Idle slots scramble the qualifiers so stale values never look valid
  task automatic put(input logic v, input nvtc_op_t k, input logic [1:0] l, input logic [1:0] i);
    junk = junk + 4'h7;
    opValid = v;
    opKind = v ? k : nvtc_op_t'(junk);
    opLevel = v ? l : junk[1:0];
    opRedirIdx = v ? i : junk[3:2];
  endtask

  // Quiet start
  initial begin
    junk = 4'h5;
    opValid = 1'b0;
    opKind = NVTC_OP_NONE;
    opLevel = 2'h0;
    opRedirIdx = 2'h0;
  end
endmodule

`default_nettype wire

/* File: testbench/nested_virt_trap_control_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "nvtc_defines.svh"

module nested_virt_trap_control_bench import nvtc_pkg::*;;
  typedef struct packed {
    logic trap;
    logic [5:0] cls;
    logic undef;
    logic redir;
    logic [1:0] idx;
    logic lvlRead;
    logic [1:0] lvl;
  } nvtc_exp_t;

  localparam logic [63:0] NEST = 64'h1 << `NVTC_POS_NEST;
  localparam logic [63:0] REDIR = 64'h1 << `NVTC_POS_REDIR;
  localparam logic [63:0] DESC = 64'h1 << `NVTC_POS_NEST_DESC;
  localparam logic [63:0] AUTH = (64'h1 << `NVTC_POS_PAUTH) | (64'h1 << `NVTC_POS_KEY) | (64'h1 << `NVTC_POS_TXN);
  localparam logic [63:0] MASK = NEST | REDIR | DESC | AUTH;

  logic clk, rst, cfgWrite, cfgRead, cfgReadValid, tlbInvalidate, descFormatAlt;
  logic [63:0] cfgWriteData, cfgReadData, cfgQ;
  logic hypEnabled, monitorPresent, trapGeneral, hostAtHyp, secureCallTrap, fineExcReturnTrap, pauthEnabledLower;
  logic opValid, resValid, resTrap, resUndefined, resCommit, resRedirect;
  nvtc_op_t opKind;
  logic [1:0] opLevel, opRedirIdx, resRedirIdx, resLevelValue;
  logic [5:0] resClass;
  logic [6:0] ctx;
  logic [31:0] rng;
  int failures, num_checks, cycles;
  nvtc_exp_t expQ[$];
  logic [63:0] rdQ[$];
  logic [63:0] cfgTab[5];

  nvtc_pipe_model pipe_u (.clk(clk), .opValid(opValid), .opKind(opKind), .opLevel(opLevel), .opRedirIdx(opRedirIdx));

  nvtc_trap_control dut_u (.clk(clk), .rst(rst), .cfgWrite(cfgWrite), .cfgWriteData(cfgWriteData),
    .cfgRead(cfgRead), .cfgReadValid(cfgReadValid), .cfgReadData(cfgReadData), .tlbInvalidate(tlbInvalidate),
    .descFormatAlt(descFormatAlt), .hypEnabled(hypEnabled), .monitorPresent(monitorPresent),
    .trapGeneral(trapGeneral), .hostAtHyp(hostAtHyp), .secureCallTrap(secureCallTrap),
    .fineExcReturnTrap(fineExcReturnTrap), .pauthEnabledLower(pauthEnabledLower), .opValid(opValid),
    .opKind(opKind), .opLevel(opLevel), .opRedirIdx(opRedirIdx), .resValid(resValid), .resTrap(resTrap),
    .resClass(resClass), .resUndefined(resUndefined), .resCommit(resCommit), .resRedirect(resRedirect),
    .resRedirIdx(resRedirIdx), .resLevelValue(resLevelValue));

  //////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the roughly 1160 cycles of the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      print_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Reference decision, from the stored word as it stands before this edge
  function automatic nvtc_exp_t predict(nvtc_op_t k, logic [1:0] l, logic [1:0] i);
    nvtc_exp_t e;
    logic krn, nvTrap, lowEn;
    krn = hypEnabled && l == `NVTC_LVL_KERNEL;
    nvTrap = krn && cfgQ[`NVTC_POS_NEST] && !cfgQ[`NVTC_POS_REDIR];
    lowEn = hypEnabled && pauthEnabledLower && (krn || (l == `NVTC_LVL_USER && !(trapGeneral && hostAtHyp)));
    e = '0;
    e.idx = i;
    e.lvlRead = (k == NVTC_OP_READ_LEVEL);
    e.lvl = nvTrap ? `NVTC_GUEST_LEVEL : l;
    if (nvTrap && k inside {NVTC_OP_SYSREG_HYP, NVTC_OP_SYSREG_HYP_REDIR, NVTC_OP_SYSREG_ALIAS,
        NVTC_OP_SPSR_BANKED, NVTC_OP_KERNEL_SP, NVTC_OP_HYP_TRANSLATE}) e.cls = `NVTC_CLASS_SYSREG;
    else if (nvTrap && k inside {NVTC_OP_EXC_RETURN, NVTC_OP_EXC_RETURN_AUTH}) e.cls = `NVTC_CLASS_EXC_RETURN;
    else if (nvTrap && k == NVTC_OP_SECURE_CALL && !monitorPresent && secureCallTrap)
      e.cls = `NVTC_CLASS_SECURE_CALL;
    else if (krn && fineExcReturnTrap && k == NVTC_OP_EXC_RETURN_AUTH) e.cls = `NVTC_CLASS_EXC_RETURN;
    else if (lowEn && !cfgQ[`NVTC_POS_PAUTH] && k inside {NVTC_OP_PAUTH, NVTC_OP_EXC_RETURN_AUTH})
      e.cls = `NVTC_CLASS_PAUTH;
    else if (krn && !cfgQ[`NVTC_POS_KEY] && k == NVTC_OP_KEY_REG) e.cls = `NVTC_CLASS_SYSREG;
    e.trap = (e.cls != `NVTC_CLASS_NONE);
    e.undef = k == NVTC_OP_TRANSACTION && hypEnabled && l != `NVTC_LVL_HYP && !cfgQ[`NVTC_POS_TXN];
    e.redir = krn && cfgQ[`NVTC_POS_NEST] && cfgQ[`NVTC_POS_REDIR] && k == NVTC_OP_SYSREG_HYP_REDIR;
    return e;
  endfunction

  // One cycle of stimulus; the expectation is noted as the request goes out
  task automatic step(input logic wr, input logic [63:0] wd, input logic rd, input logic inv,
                      input logic v, input nvtc_op_t k, input logic [1:0] l, input logic [1:0] i);
    @(posedge clk);
    #2;
    cfgWrite = wr;
    cfgWriteData = wd;
    cfgRead = rd;
    tlbInvalidate = inv;
    {hypEnabled, monitorPresent, trapGeneral, hostAtHyp, secureCallTrap, fineExcReturnTrap, pauthEnabledLower} = ctx;
    pipe_u.put(v, k, l, i);
    if (rd) rdQ.push_back(cfgQ);
    if (v) expQ.push_back(predict(k, l, i));
    if (wr) cfgQ = wd & MASK;
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b0, 64'h0, 1'b0, 1'b0, 1'b0, NVTC_OP_NONE, 2'h0, 2'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Result watcher, pairs each answer with the oldest note
  always @(posedge clk) begin
    nvtc_exp_t e;
    #1;
    if (cfgReadValid === 1'b1) begin
      if (rdQ.size() == 0) check("cfgReadValid", 1'b1, 1'b0);
      else check("cfgReadData", cfgReadData, rdQ.pop_front());
    end
    if (resValid === 1'b1) begin
      if (expQ.size() == 0) check("resValid", 1'b1, 1'b0);
      else begin
        e = expQ.pop_front();
        check("resTrap", resTrap, e.trap);
        check("resClass", resClass, e.cls);
        check("resUndefined", resUndefined, e.undef);
        check("resCommit", resCommit, !e.trap && !e.undef);
        check("resRedirect", resRedirect, e.redir);
        check("resRedirIdx", resRedirIdx, e.idx);
        if (e.lvlRead) check("resLevelValue", resLevelValue, e.lvl);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rng = 32'h00010118;
    {cfgWrite, cfgRead, tlbInvalidate, cfgWriteData, cfgQ, ctx} = '0;
    {hypEnabled, monitorPresent, trapGeneral, hostAtHyp, secureCallTrap, fineExcReturnTrap, pauthEnabledLower} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #2;
    rst = 1'b0;
    // Cleared word reads back, then a write is seen by the same-edge read as old
    step(1'b0, 64'h0, 1'b1, 1'b0, 1'b0, NVTC_OP_NONE, 2'h0, 2'h0);
    step(1'b1, NEST | DESC | 64'hFFFF, 1'b1, 1'b0, 1'b0, NVTC_OP_NONE, 2'h0, 2'h0);
    idle(2);
    check("descFormatAlt", descFormatAlt, 1'b0);
    step(1'b0, 64'h0, 1'b1, 1'b1, 1'b0, NVTC_OP_NONE, 2'h0, 2'h0);
    idle(1);
    check("descFormatAlt", descFormatAlt, 1'b1);
    // Every op kind, kernel and user, under each field mix, back to back
    cfgTab = '{NEST | AUTH, NEST | REDIR | AUTH, 64'h0, NEST, REDIR | DESC};
    foreach (cfgTab[c]) begin
      for (int f = 0; f < 4; f++) begin
        ctx = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, f[0], 1'b1};
        step(1'b1, cfgTab[c], 1'b1, 1'b0, 1'b0, NVTC_OP_NONE, 2'h0, 2'h0);
        for (int k = 0; k < 16; k++) begin
          step(1'b0, 64'h0, 1'b0, 1'b0, 1'b1, nvtc_op_t'(k), {1'b0, ~f[1]}, k[1:0]);
        end
      end
    end
    // Random mix of context, writes, reads and gaps
    repeat (800) begin
      logic [31:0] r;
      r = rnd();
      ctx = r[6:0];
      step(r[9:7] == 3'h0, {rnd(), rnd()}, r[12:10] == 3'h0, r[16:13] == 4'h0, r[18:17] != 2'h0,
           nvtc_op_t'(r[22:19]), (r[24:23] == 2'h3) ? 2'h1 : r[24:23], r[26:25]);
    end
    idle(4);
    check("pendingResults", expQ.size(), 0);
    check("pendingReads", rdQ.size(), 0);
    print_verdict();
  end
endmodule

`default_nettype wire
